// >>> pimu_checker.sv
// assertion checker of the interrupt mask unit, bound to its top ports
`timescale 1ns/1ns
module pimu_checker (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire pimu_pkg::pimu_addr_type paddr,
  input wire pimu_pkg::pimu_data_type pwdata,
  input wire pimu_pkg::pimu_data_type prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    irq_out_n
);
  import pimu_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // helper decode and shadow copies of the masks
  // --------------------------------------------------------------
  wire logic [9:0] word_w   = paddr[11:2];                     // word index
  wire logic       mapped_w = word_w >= 10'h001 && word_w <= 10'h005;
  wire logic       mask_w   = word_w == 10'h003 || word_w == 10'h004;
  wire logic       done_w   = psel && penable && pready;       // last edge
  logic      [5:0] shadow_a_r;                                 // mask a copy
  logic      [5:0] shadow_b_r;                                 // mask b copy
  wire logic       all_masked_w = &{shadow_a_r, shadow_b_r};
  // shadows follow the completing write edge, where the design stores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_a_r <= 6'h00;
      shadow_b_r <= 6'h00;
    end else if (done_w && pwrite && word_w == 10'h003) begin
      shadow_a_r <= pwdata[5:0];
    end else if (done_w && pwrite && word_w == 10'h004) begin
      shadow_b_r <= pwdata[5:0];
    end
  end
  // --------------------------------------------------------------
  // sequences and assertions
  // --------------------------------------------------------------
  sequence access_start_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence masked_hold_s;
    all_masked_w [*2];
  endsequence
  wait_one_a: assert property (access_start_s |=> pready)
    else $error("ready not one cycle into the access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  unmapped_err_a: assert property (done_w && !mapped_w |-> pslverr)
    else $error("unmapped access not refused");
  unmapped_rd_a: assert property (done_w && !pwrite && !mapped_w |->
    prdata == 32'h0000_0000)
    else $error("unmapped read data not zero");
  mapped_ok_a: assert property (done_w && mapped_w |-> !pslverr)
    else $error("error on a mapped register");
  mask_resv_a: assert property (done_w && !pwrite && mask_w |->
    prdata[31:6] == 26'h000_0000)
    else $error("reserved mask bits not zero");
  mask_a_read_a: assert property (done_w && !pwrite &&
    word_w == 10'h003 |-> prdata[5:0] == shadow_a_r)
    else $error("mask a read back wrong");
  mask_b_read_a: assert property (done_w && !pwrite &&
    word_w == 10'h004 |-> prdata[5:0] == shadow_b_r)
    else $error("mask b read back wrong");
  cond_top_a: assert property (done_w && !pwrite &&
    word_w == 10'h005 |-> prdata[31:6] == 26'h000_0000)
    else $error("condition top bits not zero");
  masked_quiet_a: assert property (masked_hold_s |-> irq_out_n)
    else $error("interrupt low with every source masked");
  irq_cause_a: assert property ($fell(irq_out_n) |->
    !$past(all_masked_w))
    else $error("interrupt fell while all masked");
  refuse_seen_c: cover property (done_w && pslverr);
endmodule

bind pimu_top pimu_checker pimu_checker_i (
  .pclk      (pclk),
  .presetn   (presetn),
  .psel      (psel),
  .penable   (penable),
  .pwrite    (pwrite),
  .paddr     (paddr),
  .pwdata    (pwdata),
  .prdata    (prdata),
  .pready    (pready),
  .pslverr   (pslverr),
  .irq_out_n (irq_out_n)
);

// >>> pimu_defs.svh
// constants of the interrupt mask unit: offsets, fields, resets, widths
`ifndef PIMU_DEFS_SVH
`define PIMU_DEFS_SVH

// ---------------------------------------------------------------------
// register indices and byte addresses (byte address = 4 * index)
// ---------------------------------------------------------------------
`define PIMU_IDX_FLAG_A     8'h01
`define PIMU_IDX_FLAG_B     8'h02
`define PIMU_IDX_MASK_A     8'h03
`define PIMU_IDX_MASK_B     8'h04
`define PIMU_IDX_COND       8'h05
`define PIMU_ADDR_W         12
`define PIMU_ADDR_FLAG_A    12'h004
`define PIMU_ADDR_FLAG_B    12'h008
`define PIMU_ADDR_MASK_A    12'h00c
`define PIMU_ADDR_MASK_B    12'h010
`define PIMU_ADDR_COND      12'h014

// ---------------------------------------------------------------------
// field layout and reset values
// ---------------------------------------------------------------------
`define PIMU_SRC_W          6
`define PIMU_RESV_W         2
`define PIMU_MASK_RST       6'h00
`define PIMU_FLAG_RST       6'h00
`define PIMU_COND_TOP       2'h0
`define PIMU_SYNC_W         16
// pin history valid one edge after this count is reached
`define PIMU_WARM_LAST      2'h2
// mask a / flag a bit positions
`define PIMU_BIT_LOW_PROG   5
`define PIMU_BIT_ADAPTER    4
`define PIMU_BIT_BUTTON     3
`define PIMU_BIT_THERMAL    2
`define PIMU_BIT_COIN_ACQ   1
`define PIMU_BIT_NVM_DONE   0
// mask b / flag b bit positions
`define PIMU_BIT_C_FAULT    5
`define PIMU_BIT_B_FAULT    4
`define PIMU_BIT_A_FAULT    3
`define PIMU_BIT_C_LIMIT    2
`define PIMU_BIT_B_LIMIT    1
`define PIMU_BIT_A_LIMIT    0

`endif

// >>> pimu_flag_bank.sv
// six sticky interrupt flags, set wins over clear
`timescale 1ns/1ns
`include "pimu_defs.svh"
module pimu_flag_bank (
  input  wire logic pclk,
  input  wire logic presetn,
  pimu_flag_if.bank fi
);
  import pimu_pkg::*;
  genvar g;

  // ---------------------------------------------------------------
  // one flop per flag; a source event in the clearing cycle survives
  // ---------------------------------------------------------------
  generate
    for (g = 0; g < `PIMU_SRC_W; g = g + 1) begin : g_flag
      logic flag_nxt;
      assign flag_nxt = fi.set[g] | (fi.flags[g] & ~fi.clr);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fi.flags[g] <= 1'b0;
        end else begin
          fi.flags[g] <= flag_nxt;
        end
      end
    end
  endgenerate
endmodule

// >>> pimu_flag_if.sv
// carrier between the top and a sticky flag bank
`timescale 1ns/1ns
interface pimu_flag_if;
  logic [5:0] set;    // per-bit set request, held while a level source lasts
  logic       clr;    // clear all bits, one cycle
  logic [5:0] flags;  // sticky flag state
  modport bank (input set, input clr, output flags);
  modport ctrl (output set, output clr, input flags);
endinterface

// >>> pimu_host_model.sv
// host side model: an edge-sensitive interrupt input that counts events
`timescale 1ns/1ns
module pimu_host_model (
  input wire logic   pclk,
  input wire logic   presetn,
  input wire logic   irq_out_n,
  output logic [7:0] low_count
);
  logic irq_d_r;  // line level seen at the previous edge
  // count each high to low change once; a stuck line counts only once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_d_r   <= 1'b1;
      low_count <= 8'h00;
    end else begin
      irq_d_r <= irq_out_n;
      if (irq_d_r && !irq_out_n) begin
        low_count <= low_count + 8'h01;
      end
    end
  end
endmodule

// >>> pimu_pkg.sv
// types and shared decode function of the interrupt mask unit
package pimu_pkg;
  // apb slave state: one wait cycle, then ready
  typedef enum logic [0:0] {
    PIMU_ST_IDLE = 1'b0,
    PIMU_ST_RESP = 1'b1
  } pimu_apb_state_type;

  typedef logic [5:0]  pimu_src_type;
  typedef logic [11:0] pimu_addr_type;
  typedef logic [31:0] pimu_data_type;

  // word-address match used by every register decode
  function automatic logic pimu_hit(input pimu_addr_type a,
                                    input pimu_addr_type reg_addr);
    pimu_hit = (a[11:2] == reg_addr[11:2]);
  endfunction
endpackage

// >>> pimu_sync.sv
// two flip-flop synchroniser for pin-level source inputs
`timescale 1ns/1ns
`include "pimu_defs.svh"
module pimu_sync (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [`PIMU_SYNC_W-1:0] async_in,
  output logic      [`PIMU_SYNC_W-1:0] sync_out
);
  import pimu_pkg::*;
  // first stage, read only by the second stage
  logic [`PIMU_SYNC_W-1:0] meta_r;

  // ---------------------------------------------------------------
  // two stages; reset to zero so no level source shows a false event before data
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// >>> pimu_top.sv
// interrupt mask unit: apb registers, source flags, interrupt pin
`timescale 1ns/1ns
`include "pimu_defs.svh"
module pimu_top (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  // answer comes one cycle into access
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire pimu_pkg::pimu_addr_type paddr,
  input  wire pimu_pkg::pimu_data_type pwdata,
  output pimu_pkg::pimu_data_type      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // interrupt toward the host, active low
  output logic                  irq_out_n,
  // pin and monitor inputs, asynchronous to pclk
  // pins read active low in the condition word
  input  wire logic             adapter_detect_in,
  input  wire logic             push_button_in,
  // monitor levels, high is active
  input  wire logic             low_prog_volt_src,
  input  wire logic             thermal_warn_src,
  input  wire logic             coin_acq_done_src,
  input  wire logic             nvm_prog_done_src,
  // load switch monitors
  input  wire logic             switch_a_fault_src,
  input  wire logic             switch_b_fault_src,
  input  wire logic             switch_c_fault_src,
  input  wire logic             switch_a_limit_src,
  input  wire logic             switch_b_limit_src,
  input  wire logic             switch_c_limit_src,
  // live fields for the condition word
  input  wire logic [1:0]       pmic_state_in,
  input  wire logic [1:0]       coin_charge_in
);
  import pimu_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // input capture
  logic [`PIMU_SYNC_W-1:0] raw_in;        // all outside inputs
  logic [`PIMU_SYNC_W-1:0] syn;           // synchronised copy
  logic                    adapter_s;     // adapter pin, synced
  logic                    button_s;      // button pin, synced
  // pin change detection
  logic [1:0]              warm_r;        // edges since reset
  logic [1:0]              warm_nxt;
  logic                    adapter_d_r;   // last adapter level
  logic                    button_d_r;    // last button level
  logic                    edge_seen_r;   // history valid
  logic                    adapter_chg;   // adapter level change
  logic                    button_chg;    // button level change
  // flag and mask state
  pimu_src_type            set_a;         // flag a set vector
  pimu_src_type            set_b;         // flag b set vector
  pimu_src_type            mask_a_r;      // source_mask_a
  pimu_src_type            mask_a_nxt;
  pimu_src_type            mask_b_r;      // source_mask_b
  pimu_src_type            mask_b_nxt;
  pimu_src_type            live_a;        // unmasked pending a
  pimu_src_type            live_b;        // unmasked pending b
  logic                    irq_nxt;       // next pin level
  logic [5:0]              cond_live;     // live condition bits
  // apb control
  pimu_apb_state_type      st_r;          // apb state
  pimu_apb_state_type      st_nxt;
  logic                    acc;           // access phase seen
  logic                    done;          // completing edge
  // register decode
  logic                    hit_fa;        // flag a decode
  logic                    hit_fb;        // flag b decode
  logic                    hit_ma;        // mask a decode
  logic                    hit_mb;        // mask b decode
  logic                    hit_cond;      // condition decode
  logic                    hit_any;       // mapped address
  logic                    wr_ma;         // write mask a
  logic                    wr_mb;         // write mask b
  logic                    rd_fa;         // read flag a
  logic                    rd_fb;         // read flag b
  // read path and response
  pimu_data_type           rd_mux;        // read data select
  logic                    ready_nxt;
  logic                    err_nxt;

  // flag bank carriers
  pimu_flag_if fa_if ();
  pimu_flag_if fb_if ();

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  // every pin and monitor bit crosses two flops before use
  // bit order: pins, flag a, flag b, fields
  assign raw_in = {coin_charge_in, pmic_state_in,
                   switch_c_fault_src, switch_b_fault_src,
                   switch_a_fault_src, switch_c_limit_src,
                   switch_b_limit_src, switch_a_limit_src,
                   low_prog_volt_src, thermal_warn_src,
                   coin_acq_done_src, nvm_prog_done_src,
                   push_button_in, adapter_detect_in};

  // one synchroniser for all inputs
  pimu_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_in),
    .sync_out (syn)
  );

  // pins sit in the two lowest bits
  assign adapter_s = syn[0];
  assign button_s  = syn[1];

  // ---------------------------------------------------------------
  // change detection for the two pins
  // ---------------------------------------------------------------
  // the synchroniser leaves reset at zero, so a pin idling high
  // would look like a change; compare only once real levels fill
  // both stages and the history, three edges after release
  assign warm_nxt = (warm_r == `PIMU_WARM_LAST) ? warm_r
                                                : warm_r + 2'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // empty history, no compare yet
      adapter_d_r <= 1'b0;
      button_d_r  <= 1'b0;
      warm_r      <= 2'h0;
      edge_seen_r <= 1'b0;
    end else begin
      // last synced level of each pin
      adapter_d_r <= adapter_s;
      button_d_r  <= button_s;
      warm_r      <= warm_nxt;
      edge_seen_r <= edge_seen_r | (warm_r == `PIMU_WARM_LAST);
    end
  end

  // either direction counts as a change
  assign adapter_chg = edge_seen_r & (adapter_s ^ adapter_d_r);
  assign button_chg  = edge_seen_r & (button_s ^ button_d_r);

  // ---------------------------------------------------------------
  // flag set vectors
  // ---------------------------------------------------------------
  // sources are recorded whatever the masks hold
  // level sources keep setting their flag while the condition lasts
  always_comb begin
    // no set request unless a source fires
    set_a = '0;
    set_a[`PIMU_BIT_LOW_PROG] = syn[5];
    // pins record changes, not levels
    set_a[`PIMU_BIT_ADAPTER]  = adapter_chg;
    set_a[`PIMU_BIT_BUTTON]   = button_chg;
    set_a[`PIMU_BIT_THERMAL]  = syn[4];
    set_a[`PIMU_BIT_COIN_ACQ] = syn[3];
    set_a[`PIMU_BIT_NVM_DONE] = syn[2];
  end

  always_comb begin
    // no set request unless a source fires
    set_b = '0;
    // faults high half, limits low half
    set_b[`PIMU_BIT_C_FAULT] = syn[11];
    set_b[`PIMU_BIT_B_FAULT] = syn[10];
    set_b[`PIMU_BIT_A_FAULT] = syn[9];
    set_b[`PIMU_BIT_C_LIMIT] = syn[8];
    set_b[`PIMU_BIT_B_LIMIT] = syn[7];
    set_b[`PIMU_BIT_A_LIMIT] = syn[6];
  end

  // live condition: adapter and button read active when pin is low
  // passed through live, never stored
  assign cond_live = {~adapter_s, ~button_s,
                      syn[13:12], syn[15:14]};

  // ---------------------------------------------------------------
  // flag banks; a read of a flag register clears it
  // ---------------------------------------------------------------
  // a completing flag read clears its whole bank
  assign fa_if.set = set_a;
  assign fa_if.clr = rd_fa;
  assign fb_if.set = set_b;
  assign fb_if.clr = rd_fb;

  // bank a: general sources
  pimu_flag_bank u_flag_a (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (fa_if)
  );

  // bank b: load switch sources
  pimu_flag_bank u_flag_b (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (fb_if)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // word match on bits 11:2 only
  assign hit_fa   = pimu_hit(paddr, `PIMU_ADDR_FLAG_A);
  assign hit_fb   = pimu_hit(paddr, `PIMU_ADDR_FLAG_B);
  assign hit_ma   = pimu_hit(paddr, `PIMU_ADDR_MASK_A);
  assign hit_mb   = pimu_hit(paddr, `PIMU_ADDR_MASK_B);
  assign hit_cond = pimu_hit(paddr, `PIMU_ADDR_COND);
  // any of the five words
  assign hit_any  = hit_fa | hit_fb | hit_ma | hit_mb | hit_cond;

  // access phase, and the edge at which it completes
  assign acc  = psel & penable;
  assign done = acc & (st_r == PIMU_ST_RESP);

  // only completing transfers act on state
  // writes to flag or condition words do nothing
  assign wr_ma = done & pwrite & hit_ma;
  assign wr_mb = done & pwrite & hit_mb;
  assign rd_fa = done & ~pwrite & hit_fa;
  assign rd_fb = done & ~pwrite & hit_fb;

  // ---------------------------------------------------------------
  // apb state: one wait cycle keeps all outputs registered
  // ---------------------------------------------------------------
  always_comb begin
    // stay unless a branch moves on
    st_nxt = st_r;
    unique case (st_r)
      PIMU_ST_IDLE: begin
        // a lone setup cycle waits here
        // access phase seen: answer on the next edge
        if (acc) begin
          st_nxt = PIMU_ST_RESP;
        end
      end
      PIMU_ST_RESP: begin
        // the answer lasts one cycle
        st_nxt = PIMU_ST_IDLE;
      end
    endcase
  end

  // ready rises for exactly the completing cycle
  assign ready_nxt = (st_nxt == PIMU_ST_RESP);
  // unmapped words answer with an error
  assign err_nxt   = ready_nxt & ~hit_any;

  // pready and pslverr rise together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle, no answer showing
      st_r    <= PIMU_ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // answer flops follow the next state
      st_r    <= st_nxt;
      pready  <= ready_nxt;
      pslverr <= err_nxt;
    end
  end

  // ---------------------------------------------------------------
  // mask registers; only the six low bits are stored
  // ---------------------------------------------------------------
  // reserved bits 7-6 have no storage, so writes vanish
  // reserved bits set in a write still store the six
  assign mask_a_nxt = wr_ma ? pwdata[`PIMU_SRC_W-1:0] : mask_a_r;
  assign mask_b_nxt = wr_mb ? pwdata[`PIMU_SRC_W-1:0] : mask_b_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // every source starts unmasked
      mask_a_r <= `PIMU_MASK_RST;
      mask_b_r <= `PIMU_MASK_RST;
    end else begin
      // hold unless a completing write
      mask_a_r <= mask_a_nxt;
      mask_b_r <= mask_b_nxt;
    end
  end

  // ---------------------------------------------------------------
  // read data select
  // ---------------------------------------------------------------
  // data is sampled at the edge that ends the request's wait cycle; flag
  // reads return the value seen then and clear at completion, so a
  // flag set in between is cleared unread unless its set request still holds at completion
  always_comb begin
    // unused bits and unmapped words read zero
    rd_mux = '0;
    if (hit_fa) begin
      // general flags
      rd_mux[`PIMU_SRC_W-1:0] = fa_if.flags;
    end else if (hit_fb) begin
      // load switch flags
      rd_mux[`PIMU_SRC_W-1:0] = fb_if.flags;
    end else if (hit_ma) begin
      // mask a, six stored bits
      rd_mux[`PIMU_SRC_W-1:0] = mask_a_r;
    end else if (hit_mb) begin
      // mask b, six stored bits
      rd_mux[`PIMU_SRC_W-1:0] = mask_b_r;
    end else if (hit_cond) begin
      // two fixed zeros over live fields
      rd_mux[7:0] = {`PIMU_COND_TOP, cond_live};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // no stale data after reset
      prdata <= '0;
    end else if (acc & ~pwrite & (st_r == PIMU_ST_IDLE)) begin
      // loaded once per read; writes leave it alone
      prdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------
  // a set mask bit hides its flag from the pin, nothing more
  // one unmasked pending flag pulls the line
  assign live_a  = fa_if.flags & ~mask_a_r;
  assign live_b  = fb_if.flags & ~mask_b_r;
  assign irq_nxt = ~(|live_a | |live_b);

  // registered so the pin never glitches on decode changes; this
  // costs one cycle of latency after a flag or mask change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // line released
      irq_out_n <= 1'b1;
    end else begin
      // low while any unmasked flag pends
      irq_out_n <= irq_nxt;
    end
  end
endmodule

// >>> tb_pimu_top.sv
// self-checking bench of the interrupt mask unit over apb
`timescale 1ns/1ns
`include "pimu_defs.svh"
module tb_pimu_top;
  import pimu_pkg::*;
  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  pimu_addr_type paddr;
  pimu_data_type pwdata;
  pimu_data_type prdata;
  logic          pready;
  logic          pslverr;
  logic          irq_out_n;
  logic [11:0]   src;        // {flag b sources, flag a sources} by bit
  logic [1:0]    state_in;   // state field source
  logic [1:0]    charge_in;  // coin charge field source
  logic [7:0]    low_count;  // events seen by the host model
  logic [7:0]    cnt;        // event count before a source test
  pimu_data_type rd;         // last read data
  logic          er;         // last error response
  pimu_addr_type fa;         // flag register under test
  pimu_addr_type ma;         // mask register under test
  pimu_data_type bitv;       // bit under test
  int            fail_count;
  int            comparisons;

  pimu_top pimu_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_out_n(irq_out_n),
    .adapter_detect_in(src[4]), .push_button_in(src[3]),
    .low_prog_volt_src(src[5]), .thermal_warn_src(src[2]),
    .coin_acq_done_src(src[1]), .nvm_prog_done_src(src[0]),
    .switch_a_fault_src(src[9]), .switch_b_fault_src(src[10]),
    .switch_c_fault_src(src[11]), .switch_a_limit_src(src[6]),
    .switch_b_limit_src(src[7]), .switch_c_limit_src(src[8]),
    .pmic_state_in(state_in), .coin_charge_in(charge_in)
  );
  pimu_host_model pimu_host_model_i (
    .pclk(pclk), .presetn(presetn), .irq_out_n(irq_out_n),
    .low_count(low_count)
  );
  // ------------------------------------------------------------------
  // clock and report
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_data(input pimu_data_type got, input pimu_data_type exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ------------------------------------------------------------------
  // apb master: hold the request until pready is seen at an edge
  // ------------------------------------------------------------------
  task automatic apb(input logic wr, input pimu_addr_type a,
                     input pimu_data_type wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    // a hung slave ends the run at once
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input pimu_addr_type a, input pimu_data_type exp,
                        input logic exp_er);
    apb(1'b0, a, 32'h0000_0000);
    chk_data(rd, exp);
    chk_bit(er, exp_er);
  endtask
  // one source pulse, then time for sync and flag to settle
  task automatic pulse(input int i);
    src <= 12'h001 << i;
    repeat (2) @(posedge pclk);
    src <= 12'h000;
    repeat (8) @(posedge pclk);
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    fail_count  = 0;
    comparisons = 0;
    presetn   <= 1'b0;
    psel      <= 1'b0;
    penable   <= 1'b0;
    pwrite    <= 1'b0;
    paddr     <= 12'h000;
    pwdata    <= 32'h0000_0000;
    src       <= 12'h000;
    state_in  <= 2'h2;
    charge_in <= 2'h1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`PIMU_ADDR_MASK_A, 32'h0000_0000, 1'b0);
    rd_chk(`PIMU_ADDR_MASK_B, 32'h0000_0000, 1'b0);
    rd_chk(`PIMU_ADDR_FLAG_A, 32'h0000_0000, 1'b0);
    rd_chk(`PIMU_ADDR_FLAG_B, 32'h0000_0000, 1'b0);
    rd_chk(`PIMU_ADDR_COND, 32'h0000_0039, 1'b0);
    apb(1'b1, `PIMU_ADDR_MASK_A, 32'hffff_ffff);
    rd_chk(`PIMU_ADDR_MASK_A, 32'h0000_003f, 1'b0);
    apb(1'b1, `PIMU_ADDR_MASK_B, 32'hffff_ffff);
    rd_chk(`PIMU_ADDR_MASK_B, 32'h0000_003f, 1'b0);
    // unmapped word: refused both ways
    apb(1'b1, 12'h018, 32'h0000_0001);
    chk_bit(er, 1'b1);
    rd_chk(12'h018, 32'h0000_0000, 1'b1);
    // every source: masked it only records, unmasked it pulls the line
    for (int i = 0; i < 12; i++) begin
      fa   = (i < 6) ? `PIMU_ADDR_FLAG_A : `PIMU_ADDR_FLAG_B;
      ma   = (i < 6) ? `PIMU_ADDR_MASK_A : `PIMU_ADDR_MASK_B;
      bitv = 32'h0000_0001 << (i % 6);
      cnt  = low_count;
      pulse(i);
      chk_bit(irq_out_n, 1'b1);
      chk_data({24'h00_0000, low_count}, {24'h00_0000, cnt});
      rd_chk(fa, bitv, 1'b0);
      rd_chk(fa, 32'h0000_0000, 1'b0);
      pulse(i);
      apb(1'b1, ma, 32'h0000_003f & ~bitv);
      repeat (3) @(posedge pclk);
      chk_bit(irq_out_n, 1'b0);
      chk_data({24'h00_0000, low_count}, {24'h00_0000, cnt + 8'h01});
      rd_chk(fa, bitv, 1'b0);
      repeat (3) @(posedge pclk);
      chk_bit(irq_out_n, 1'b1);
      apb(1'b1, ma, 32'h0000_003f);
    end
    print_verdict();
  end
endmodule
